// ==== design/mtcr_host.sv ====
// Host end: Avalon-MM slave that writes the FIFO and clears the flag.
`timescale 1ns/100ps
module mtcr_host
   import mtcr_pkg::*;
#(
   parameter int STROBE_HALF = STROBE_HALF_CYCLES
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Avalon-MM slave
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Port side
   mtcr_if.host dif
);
   mtcr_host_state_t state_reg;
   logic [7:0] cnt_reg;
   logic [4:0] ctrl_reg;
   logic half_done;

   assign half_done = cnt_reg == 8'(STROBE_HALF - 1);
   assign avs_waitrequest = (avs_read | avs_write) & (state_reg != HS_ACK);
   assign dif.host_port_select = ctrl_reg[1:0];
   assign dif.single_attempt_select = ctrl_reg[CTRL_ONE_BIT];
   assign dif.suppress_crc = ctrl_reg[CTRL_SUP_BIT];
   assign dif.retry_flag_output_enable_n = ~ctrl_reg[CTRL_OE_BIT];

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= HS_IDLE;
         cnt_reg <= 8'h00;
         ctrl_reg <= HOST_CTRL_RESET;
         avs_readdata <= 32'h00000000;
         dif.fifo_strobe_clock <= 1'b0;
         dif.fifo_write <= 1'b0;
         dif.fifo_data <= 32'h00000000;
         dif.fifo_end_of_frame_marker <= 1'b0;
         dif.clear_tx_retry <= 1'b0;
      end else begin
         cnt_reg <= half_done ? 8'h00 : cnt_reg + 8'h01;
         case (state_reg)
            HS_IDLE: begin
               cnt_reg <= 8'h00;
               if (avs_read) begin
                  avs_readdata <= 32'h00000000;
                  if (avs_address == HOST_STATUS_OFS) begin
                     avs_readdata <= {30'h00000000, dif.tx_retry_level, dif.tx_fifo_ready};
                  end else if (avs_address == HOST_CTRL_OFS) begin
                     avs_readdata <= {27'h0000000, ctrl_reg};
                  end
                  state_reg <= HS_ACK;
               end else if (avs_write) begin
                  state_reg <= HS_ACK;
                  if (avs_address == HOST_DATA_OFS || avs_address == HOST_LAST_OFS) begin
                     dif.fifo_data <= avs_writedata;
                     dif.fifo_end_of_frame_marker <= avs_address == HOST_LAST_OFS;
                     dif.fifo_write <= 1'b1;
                     state_reg <= HS_SETUP;
                  end else if (avs_address == HOST_CLEAR_OFS) begin
                     dif.clear_tx_retry <= 1'b1;
                     state_reg <= HS_SETUP;
                  end else if (avs_address == HOST_CTRL_OFS) begin
                     ctrl_reg <= avs_writedata[4:0];
                  end
               end
            end
            HS_SETUP: begin
               if (half_done) begin
                  dif.fifo_strobe_clock <= 1'b1;
                  state_reg <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               if (half_done) begin
                  dif.fifo_strobe_clock <= 1'b0;
                  state_reg <= HS_LOW;
               end
            end
            HS_LOW: begin
               if (half_done) begin
                  dif.fifo_write <= 1'b0;
                  dif.fifo_end_of_frame_marker <= 1'b0;
                  dif.clear_tx_retry <= 1'b0;
                  state_reg <= HS_ACK;
               end
            end
            HS_ACK: begin
               state_reg <= HS_IDLE;
            end
            default: begin
               state_reg <= HS_IDLE;
            end
         endcase
      end
   end
endmodule : mtcr_host

// ==== design/mtcr_if.sv ====
// Interface joining the host end and the port end.
`timescale 1ns/100ps
interface mtcr_if;
   logic fifo_strobe_clock;
   logic fifo_write;
   logic [31:0] fifo_data;
   logic fifo_end_of_frame_marker;
   logic suppress_crc;
   logic clear_tx_retry;
   logic [1:0] host_port_select;
   logic retry_flag_output_enable_n;
   logic single_attempt_select;
   logic tx_fifo_ready;
   logic tx_retry_flag;
   logic tx_retry_flag_oe;
   logic tx_retry_level;

   // The flag pin reads low while nobody drives it.
   assign tx_retry_level = tx_retry_flag_oe & tx_retry_flag;

   modport dev (
      input fifo_strobe_clock, fifo_write, fifo_data, fifo_end_of_frame_marker,
      input suppress_crc, clear_tx_retry, host_port_select,
      input retry_flag_output_enable_n, single_attempt_select,
      output tx_fifo_ready, tx_retry_flag, tx_retry_flag_oe
   );

   modport host (
      output fifo_strobe_clock, fifo_write, fifo_data, fifo_end_of_frame_marker,
      output suppress_crc, clear_tx_retry, host_port_select,
      output retry_flag_output_enable_n, single_attempt_select,
      input tx_fifo_ready, tx_retry_level
   );
endinterface : mtcr_if

// ==== design/mtcr_pkg.sv ====
// Shared constants and types for the transmit collision recovery block.
package mtcr_pkg;
   localparam int FIFO_DEPTH = 32;
   localparam int EOF_BIT = 32;
   localparam int SUP_BIT = 33;
   localparam logic [31:0] JAM_WORD = 32'h55555555;
   localparam logic [3:0] PRE_NIBBLE = 4'h5;
   localparam logic [3:0] SFD_NIBBLE = 4'hD;
   localparam logic [3:0] PRE_LAST = 4'hF;
   localparam logic [3:0] WORD_LAST = 4'h7;
   localparam logic [7:0] LATE_NIBBLES = 8'h80;
   localparam logic [3:0] XS_ATTEMPT = 4'hF;
   localparam logic [3:0] BACKOFF_K_MAX = 4'hA;
   localparam int CLK_PERIOD_NS = 8;
   localparam int SLOT_TIME_NS = 5120;
   localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] CRC_POLY = 32'hEDB88320;
   localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
   localparam logic [15:0] LFSR_SEED_DEF = 16'hACE1;
   localparam int CFG1_NO_CRC_BIT = 4;
   localparam int TS_UNDER_BIT = 0;
   localparam int TS_COLL_BIT = 1;
   localparam int TS_XS_BIT = 2;
   localparam int TS_CRS_BIT = 3;
   localparam int TS_LATE_BIT = 4;
   localparam int TS_OK_BIT = 5;
   localparam logic [4:0] HOST_DATA_OFS = 5'h00;
   localparam logic [4:0] HOST_LAST_OFS = 5'h04;
   localparam logic [4:0] HOST_CLEAR_OFS = 5'h08;
   localparam logic [4:0] HOST_CTRL_OFS = 5'h0C;
   localparam logic [4:0] HOST_STATUS_OFS = 5'h10;
   localparam logic [4:0] HOST_CTRL_RESET = 5'h10;
   localparam int CTRL_ONE_BIT = 2;
   localparam int CTRL_SUP_BIT = 3;
   localparam int CTRL_OE_BIT = 4;
   localparam int STROBE_HALF_CYCLES = 4;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_PRE = 6'h02,
      ST_DATA = 6'h04,
      ST_CRC = 6'h08,
      ST_JAM = 6'h10,
      ST_BACKOFF = 6'h20
   } mtcr_tx_state_t;

   typedef enum logic [4:0] {
      HS_IDLE = 5'h01,
      HS_SETUP = 5'h02,
      HS_HIGH = 5'h04,
      HS_LOW = 5'h08,
      HS_ACK = 5'h10
   } mtcr_host_state_t;
endpackage : mtcr_pkg

// ==== design/mtcr_port_tx.sv ====
// Transmit termination and collision recovery for one port.
//
// The implementer's own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module mtcr_port_tx
   import mtcr_pkg::*;
#(
   parameter logic [1:0] PORT_INDEX = 2'h0,
   parameter int SLOT_CYCLES_P = SLOT_CYCLES,
   parameter logic [15:0] LFSR_SEED = LFSR_SEED_DEF
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Host side
   mtcr_if.dev hif,
   // Transceiver side
   input wire logic phy_tx_clk,
   input wire logic carrier_sense_in,
   input wire logic collision_in,
   output logic tx_en,
   output logic [3:0] tx_data,
   // Configuration and status
   input wire logic [7:0] config_word1,
   input wire logic [7:0] irq_enable,
   output logic [7:0] tx_status_word,
   output logic tx_status_load,
   output logic tx_irq,
   output logic [15:0] tx_collision_count
);
   localparam int PW = $clog2(FIFO_DEPTH) + 1;
   localparam int AW = PW - 1;

   // ---------------------------------------------------------------
   // Input synchronisers and edge detection.
   // ---------------------------------------------------------------
   logic [40:0] hs1_reg;
   logic [40:0] hs2_reg;
   logic [2:0] ps1_reg;
   logic [2:0] ps2_reg;
   logic strb_d_reg;
   logic tclk_d_reg;
   logic [1:0] sel_s;
   logic oen_s;
   logic one_s;
   logic clr_s;
   logic strb_s;
   logic wr_s;
   logic [33:0] entry_s;
   logic tclk_s;
   logic crs_s;
   logic col_s;
   logic strobe_rise;
   logic nib_en;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         hs1_reg <= '0;
         hs2_reg <= '0;
         ps1_reg <= '0;
         ps2_reg <= '0;
         strb_d_reg <= 1'b0;
         tclk_d_reg <= 1'b0;
      end else begin
         hs1_reg <= {hif.host_port_select, hif.retry_flag_output_enable_n,
                     hif.single_attempt_select, hif.clear_tx_retry, hif.fifo_strobe_clock,
                     hif.fifo_write, hif.suppress_crc, hif.fifo_end_of_frame_marker,
                     hif.fifo_data};
         hs2_reg <= hs1_reg;
         ps1_reg <= {phy_tx_clk, carrier_sense_in, collision_in};
         ps2_reg <= ps1_reg;
         strb_d_reg <= strb_s;
         tclk_d_reg <= tclk_s;
      end
   end

   assign {sel_s, oen_s, one_s, clr_s, strb_s, wr_s, entry_s} = hs2_reg;
   assign {tclk_s, crs_s, col_s} = ps2_reg;
   assign strobe_rise = strb_s & ~strb_d_reg;
   assign nib_en = tclk_s & ~tclk_d_reg;

   // ---------------------------------------------------------------
   // Transmit FIFO.
   // ---------------------------------------------------------------
   logic [33:0] mem [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW-1:0] start_ptr_reg;
   logic flag_reg;
   logic full;
   logic empty;
   logic wr_fire;
   logic pop;
   logic rewind;

   assign full = (wr_ptr_reg - start_ptr_reg) == PW'(FIFO_DEPTH);
   assign empty = rd_ptr_reg == wr_ptr_reg;
   assign wr_fire = strobe_rise & wr_s & ~flag_reg & ~full;
   assign hif.tx_fifo_ready = ~flag_reg & ~full;

   always_ff @(posedge sys_clk) begin
      if (wr_fire) begin
         mem[wr_ptr_reg[AW-1:0]] <= entry_s;
      end
   end

   // ---------------------------------------------------------------
   // Transmit state machine.
   // ---------------------------------------------------------------
   mtcr_tx_state_t state_reg;
   mtcr_tx_state_t state_next;
   logic [3:0] nib_cnt_reg;
   logic [7:0] frame_nib_reg;
   logic [33:0] word_reg;
   logic [31:0] crc_reg;
   logic [23:0] bo_cnt_reg;
   logic crs_seen_reg;
   logic [3:0] attempt_reg;
   logic [15:0] lfsr_reg;
   logic [3:0] cur_nib;
   logic active;
   logic no_crc;
   logic coll;
   logic done_ok;
   logic under;
   logic crs_err;
   logic xs_e;
   logic late_e;
   logic one_e;
   logic fail;
   logic [3:0] bo_k;

   function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 4; i++) begin
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_nib

   function automatic logic [23:0] bo_len(input logic [3:0] k, input logic [9:0] rnd);
      logic [9:0] mask;
      mask = 10'((11'h001 << k) - 11'h001);
      return 24'({14'h0000, rnd & mask} * 24'(SLOT_CYCLES_P));
   endfunction : bo_len

   assign active = (state_reg == ST_PRE) || (state_reg == ST_DATA) || (state_reg == ST_CRC);
   assign no_crc = config_word1[CFG1_NO_CRC_BIT] | word_reg[SUP_BIT];

   always_comb begin
      state_next = state_reg;
      cur_nib = 4'h0;
      pop = 1'b0;
      done_ok = 1'b0;
      under = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (!flag_reg && !empty) begin
               state_next = ST_PRE;
            end
         end
         ST_PRE: begin
            cur_nib = (nib_cnt_reg == PRE_LAST) ? SFD_NIBBLE : PRE_NIBBLE;
            if (nib_en && nib_cnt_reg == PRE_LAST) begin
               pop = 1'b1;
               state_next = ST_DATA;
            end
         end
         ST_DATA: begin
            cur_nib = word_reg[{nib_cnt_reg[2:0], 2'b00} +: 4];
            if (nib_en && nib_cnt_reg == WORD_LAST) begin
               if (word_reg[EOF_BIT]) begin
                  done_ok = no_crc;
                  state_next = no_crc ? ST_IDLE : ST_CRC;
               end else if (empty) begin
                  under = 1'b1;
               end else begin
                  pop = 1'b1;
               end
            end
         end
         ST_CRC: begin
            cur_nib = ~crc_reg[3:0];
            if (nib_en && nib_cnt_reg == WORD_LAST) begin
               done_ok = 1'b1;
               state_next = ST_IDLE;
            end
         end
         ST_JAM: begin
            cur_nib = JAM_WORD[3:0];
            if (nib_en && nib_cnt_reg == WORD_LAST) begin
               state_next = ST_BACKOFF;
            end
         end
         ST_BACKOFF: begin
            if (bo_cnt_reg == 24'h000000) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      coll = nib_en & active & col_s;
      xs_e = coll & (attempt_reg == XS_ATTEMPT);
      late_e = coll & (frame_nib_reg >= LATE_NIBBLES);
      one_e = coll & one_s;
      crs_err = nib_en & active & ~coll & ((crs_seen_reg & ~crs_s) |
                (done_ok & ~crs_seen_reg & ~crs_s));
      under = under & ~coll;
      rewind = coll & ~xs_e & ~late_e & ~one_e;
      if (coll || under || crs_err) begin
         pop = 1'b0;
         done_ok = 1'b0;
      end
      if (xs_e) begin
         state_next = ST_BACKOFF;
      end else if (late_e || one_e || under || crs_err) begin
         state_next = ST_IDLE;
      end else if (rewind) begin
         state_next = ST_JAM;
      end
      fail = xs_e | late_e | one_e | under | crs_err;
      bo_k = xs_e ? BACKOFF_K_MAX : ((attempt_reg > BACKOFF_K_MAX) ? BACKOFF_K_MAX : attempt_reg);
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         nib_cnt_reg <= 4'h0;
         frame_nib_reg <= 8'h00;
         word_reg <= '0;
         crc_reg <= CRC_INIT;
         bo_cnt_reg <= 24'h000000;
         crs_seen_reg <= 1'b0;
         tx_en <= 1'b0;
         tx_data <= 4'h0;
      end else begin
         state_reg <= state_next;
         if (nib_en) begin
            tx_en <= active || (state_reg == ST_JAM);
            tx_data <= cur_nib;
            if (state_next != state_reg || (state_reg == ST_DATA && nib_cnt_reg == WORD_LAST)) begin
               nib_cnt_reg <= 4'h0;
            end else begin
               nib_cnt_reg <= nib_cnt_reg + 4'h1;
            end
            if (active && frame_nib_reg != LATE_NIBBLES) begin
               frame_nib_reg <= frame_nib_reg + 8'h01;
            end
            if (state_reg == ST_PRE) begin
               crc_reg <= CRC_INIT;
            end else if (state_reg == ST_DATA) begin
               crc_reg <= crc_nib(crc_reg, cur_nib);
            end else if (state_reg == ST_CRC) begin
               crc_reg <= crc_reg >> 4;
            end
         end
         if (state_reg == ST_IDLE) begin
            nib_cnt_reg <= 4'h0;
            frame_nib_reg <= 8'h00;
            crs_seen_reg <= 1'b0;
         end else if (active && crs_s) begin
            crs_seen_reg <= 1'b1;
         end
         if (pop) begin
            word_reg <= mem[rd_ptr_reg[AW-1:0]];
         end
         if (state_next == ST_BACKOFF && state_reg != ST_BACKOFF) begin
            bo_cnt_reg <= bo_len(bo_k, lfsr_reg[9:0]);
         end else if (state_reg == ST_BACKOFF && bo_cnt_reg != 24'h000000) begin
            bo_cnt_reg <= bo_cnt_reg - 24'h000001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pointers, flag, random source and counters.
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset || flag_reg) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         start_ptr_reg <= '0;
      end else begin
         if (wr_fire) begin
            wr_ptr_reg <= wr_ptr_reg + PW'(1);
         end
         if (rewind) begin
            rd_ptr_reg <= start_ptr_reg;
         end else if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + PW'(1);
         end
         if (state_reg == ST_IDLE) begin
            start_ptr_reg <= rd_ptr_reg;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag_reg <= 1'b0;
      end else if (fail) begin
         flag_reg <= 1'b1;
      end else if (clr_s && sel_s == PORT_INDEX && !oen_s) begin
         flag_reg <= 1'b0;
      end
   end

   assign hif.tx_retry_flag = flag_reg;
   assign hif.tx_retry_flag_oe = ~oen_s;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lfsr_reg <= LFSR_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         attempt_reg <= 4'h0;
         tx_collision_count <= 16'h0000;
      end else begin
         if (coll) begin
            attempt_reg <= attempt_reg + 4'h1;
            tx_collision_count[10:0] <= tx_collision_count[10:0] + 11'h001;
         end
         if (fail || done_ok) begin
            attempt_reg <= 4'h0;
         end
         if (done_ok) begin
            tx_collision_count[15:11] <= {1'b0, attempt_reg} + 5'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tx_status_word <= 8'h00;
         tx_status_load <= 1'b0;
         tx_irq <= 1'b0;
      end else begin
         tx_status_load <= coll | under | crs_err | done_ok;
         tx_irq <= 1'b0;
         if (coll || under || crs_err || done_ok) begin
            tx_status_word <= 8'h00;
            tx_status_word[TS_UNDER_BIT] <= under;
            tx_status_word[TS_COLL_BIT] <= coll;
            tx_status_word[TS_XS_BIT] <= xs_e;
            tx_status_word[TS_CRS_BIT] <= crs_err;
            tx_status_word[TS_LATE_BIT] <= late_e;
            tx_status_word[TS_OK_BIT] <= done_ok;
            tx_irq <= |(irq_enable & {2'b00, done_ok, late_e, crs_err, xs_e, coll, under});
         end
      end
   end
endmodule : mtcr_port_tx

// ==== dv/mtcr_assertions.sv ====
// Concurrent checks on the link between the host end and the port end.
`timescale 1ns/100ps
module mtcr_assertions #(
   parameter logic [1:0] PORT_INDEX = 2'h0
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // Link
   input wire logic clear_tx_retry,
   input wire logic [1:0] host_port_select,
   input wire logic retry_flag_output_enable_n,
   input wire logic tx_fifo_ready,
   input wire logic tx_retry_flag,
   input wire logic tx_retry_flag_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_ready_low:
   assert property (tx_retry_flag |-> !tx_fifo_ready) else $error("ready high with flag");
   a_flag_latched:
   assert property (tx_retry_flag && !clear_tx_retry && !$past(clear_tx_retry)
      && !$past(clear_tx_retry, 2) |=> tx_retry_flag) else $error("flag dropped");
   a_pin_off:
   assert property (retry_flag_output_enable_n [*4] |-> !tx_retry_flag_oe)
      else $error("pin driven while disabled");
   a_pin_on:
   assert property (!retry_flag_output_enable_n [*4] |-> tx_retry_flag_oe)
      else $error("pin not driven while enabled");
   a_clear_port:
   assert property ($fell(tx_retry_flag) |-> $past(host_port_select, 2) == PORT_INDEX)
      else $error("flag cleared for other port");
   a_clear_enabled:
   assert property ($fell(tx_retry_flag) |-> !$past(retry_flag_output_enable_n, 2))
      else $error("flag cleared while disabled");
   a_clear_pulsed:
   assert property ($fell(tx_retry_flag) |-> $past(clear_tx_retry, 2))
      else $error("flag cleared without clear");
   a_ready_back:
   assert property ($fell(tx_retry_flag) |-> tx_fifo_ready) else $error("ready low after clear");
   c_flag_set: cover property ($rose(tx_retry_flag));
   c_flag_clr: cover property ($fell(tx_retry_flag));
   c_wrong_port: cover property (tx_retry_flag && clear_tx_retry && host_port_select != PORT_INDEX);
endmodule : mtcr_assertions

// ==== dv/tb_mac_tx_collision_retry.sv ====
// Self-checking bench for the transmit collision recovery block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_mac_tx_collision_retry
   import mtcr_pkg::*;
;
   logic sys_clk = 0, reset = 1, phy_tx_clk = 0, coll_on = 0, crs_ok = 1;
   logic carrier_sense_in = 0, collision_in = 0, tx_en, tx_status_load, tx_irq;
   logic avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
   logic [7:0] config_word1 = 8'h10, tx_status_word, irq_en = 8'h20;
   logic [3:0] tx_data;
   logic [15:0] tx_collision_count;
   logic [3:0] q[$];
   int n_errors = 0, num_checks = 0;
   mtcr_if mtcr_if_i();
   always #4 sys_clk = ~sys_clk;
   always #32 phy_tx_clk = ~phy_tx_clk;
   always @(posedge sys_clk) begin
      carrier_sense_in <= tx_en & crs_ok;
      collision_in <= tx_en & coll_on;
   end
   always @(posedge phy_tx_clk) if (tx_en === 1'b1) q.push_back(tx_data);
   mtcr_port_tx #(.SLOT_CYCLES_P(2)) mtcr_port_tx_i (.sys_clk, .reset, .hif(mtcr_if_i),
      .phy_tx_clk, .carrier_sense_in, .collision_in, .tx_en, .tx_data, .config_word1,
      .irq_enable(irq_en), .tx_status_word, .tx_status_load, .tx_irq, .tx_collision_count);
   mtcr_host mtcr_host_i (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .dif(mtcr_if_i));
   mtcr_assertions #(.PORT_INDEX(2'h0)) mtcr_assertions_i (.sys_clk, .reset,
      .clear_tx_retry(mtcr_if_i.clear_tx_retry), .host_port_select(mtcr_if_i.host_port_select),
      .retry_flag_output_enable_n(mtcr_if_i.retry_flag_output_enable_n),
      .tx_fifo_ready(mtcr_if_i.tx_fifo_ready), .tx_retry_flag(mtcr_if_i.tx_retry_flag),
      .tx_retry_flag_oe(mtcr_if_i.tx_retry_flag_oe));
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask : av
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      repeat (3) @(posedge sys_clk);
      av(1'b0, a, 32'h0);
      `CHK("readdata", e, rd)
   endtask : rdchk
   task automatic send(input int n);
      for (int i = 1; i <= n; i++) begin
         av(1'b1, (i == n) ? HOST_LAST_OFS : HOST_DATA_OFS, 32'h76543210);
      end
   endtask : send
   task automatic wstat(input logic [7:0] m, input logic [7:0] e);
      do @(posedge sys_clk); while (tx_status_load !== 1'b1);
      `CHK("status", e, tx_status_word & m)
      `CHK("irq", |(e & irq_en), tx_irq)
   endtask : wstat
   task automatic frame(input int b);
      for (int i = 0; i < 24; i++) begin
         `CHK("nibble", (i < 15) ? 4'h5 : (i == 15) ? 4'hD : 4'((i - 16) % 8), q[b + i])
      end
   endtask : frame
   task automatic clr(input logic [31:0] c);
      av(1'b1, HOST_CTRL_OFS, c);
      av(1'b1, HOST_CLEAR_OFS, 32'h1);
      av(1'b1, HOST_CTRL_OFS, 32'h10);
   endtask : clr
   task automatic t_good;
      for (int c = 0; c < 3; c++) begin
         if (c == 2) begin
            av(1'b1, HOST_CTRL_OFS, 32'h18);
         end
         config_word1 <= (c == 0) ? 8'h10 : 8'h00;
         q.delete();
         send(1);
         wstat(8'hFF, 8'h20);
         repeat (24) @(posedge sys_clk);
         `CHK("nibbles", (c == 1) ? 32 : 24, q.size())
         frame(0);
      end
      `CHK("attempts", 5'h01, tx_collision_count[15:11])
      av(1'b1, HOST_CTRL_OFS, 32'h10);
      config_word1 <= 8'h10;
   endtask : t_good
   task automatic t_retry;
      irq_en <= 8'h22;
      coll_on <= 1'b1;
      send(1);
      wstat(8'hFF, 8'h02);
      coll_on <= 1'b0;
      q.delete();
      wstat(8'hFF, 8'h20);
      repeat (24) @(posedge sys_clk);
      // The nibble already on the wire at the collision edge precedes the jam.
      `CHK("nibbles", 33, q.size())
      for (int i = 1; i < 9; i++) `CHK("jam", 4'h5, q[i])
      frame(9);
      `CHK("attempts", 5'h02, tx_collision_count[15:11])
      `CHK("collisions", 11'h001, tx_collision_count[10:0])
      irq_en <= 8'h20;
   endtask : t_retry
   task automatic t_xs;
      coll_on <= 1'b1;
      send(1);
      repeat (15) wstat(8'hFF, 8'h02);
      wstat(8'hFF, 8'h06);
      coll_on <= 1'b0;
      rdchk(HOST_STATUS_OFS, 32'h2);
      `CHK("collisions", 11'h011, tx_collision_count[10:0])
      q.delete();
      av(1'b1, HOST_LAST_OFS, 32'h1);
      av(1'b1, HOST_CTRL_OFS, 32'h01);
      rdchk(HOST_STATUS_OFS, 32'h0);
      clr(32'h11);
      rdchk(HOST_STATUS_OFS, 32'h2);
      clr(32'h10);
      rdchk(HOST_STATUS_OFS, 32'h1);
      repeat (100) @(posedge sys_clk);
      `CHK("nibbles", 0, q.size())
   endtask : t_xs
   task automatic t_fail;
      av(1'b1, HOST_CTRL_OFS, 32'h14);
      coll_on <= 1'b1;
      send(1);
      wstat(8'hFF, 8'h02);
      coll_on <= 1'b0;
      rdchk(HOST_STATUS_OFS, 32'h2);
      clr(32'h10);
      crs_ok <= 1'b0;
      send(1);
      wstat(8'h08, 8'h08);
      crs_ok <= 1'b1;
      clr(32'h10);
      av(1'b1, HOST_DATA_OFS, 32'h76543210);
      wstat(8'h01, 8'h01);
      rdchk(HOST_STATUS_OFS, 32'h2);
      clr(32'h10);
      q.delete();
      send(15);
      while (q.size() < 130) @(posedge sys_clk);
      coll_on <= 1'b1;
      wstat(8'h10, 8'h10);
      coll_on <= 1'b0;
      rdchk(HOST_STATUS_OFS, 32'h2);
      clr(32'h10);
   endtask : t_fail
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      rdchk(HOST_CTRL_OFS, 32'h10);
      rdchk(HOST_STATUS_OFS, 32'h1);
      av(1'b1, 5'h18, 32'hF);
      rdchk(5'h14, 32'h0);
      t_good();
      t_retry();
      t_xs();
      t_fail();
      end_sim();
   end
   initial begin
      #700000;
      n_errors++;
      end_sim();
   end
endmodule : tb_mac_tx_collision_retry
